// ### src/llts_top.sv
`default_nettype none
// Function
// [R1] Four mailbox sets per link, one secure
// [R2] Lock refuses secure mailbox reads
// [R3] Lock bit is sticky against host writes
// [R4] Firmware: train, exchange, lock, then valid
// [R5] TPM reached only on private I2C
// [R6] Primary or secondary trigger starts sequence
// [R7] Trigger rise clears quiesced and grant
// [R8] Refresh code, then branch to entry
// [R9] All cores must report deep sleep
// [R10] Controller clocks stopped before halt requests
// [R11] Halt requests held until payload clears
// [R12] Units stay quiet while halt requested
// [R13] Check unit halts, recheck cores
// [R14] Exactly one primary else checkstop
// [R15] Set chip-quiesced flag when verified
// [R16] Wait for every peer quiesced flag
// [R17] Then set high-locality grant
// [R18] Secondary chip clears trigger, exits
// [R19] Primary clears trigger, scans, loads, starts
// [R20] Start begins verification at launch entry
// [R21] Firmware quiesces everything before triggering
// [R22] Host cannot write quiesced or grant
// [R23] Keep polling unmet quiescence conditions
module llts_top
    import llts_pkg::*;
(
    input  wire logic                        core_clk_in,
    input  wire logic                        reset_n_in,
    // Link mailbox access
    input  wire logic [LLTS_LINKS-1:0]       mbox_wr_en_in,
    input  wire logic [LLTS_LINKS-1:0]       mbox_rd_en_in,
    input  wire logic [1:0]                  mbox_sel_in,
    input  wire logic [LLTS_MBOX_W-1:0]      mbox_wdata_in,
    output logic      [LLTS_MBOX_W-1:0]      mbox_rdata_out,
    output logic                             mbox_rd_refused_out,
    // Security register bits from host
    input  wire logic                        lock_set_in,
    input  wire logic                        prim_trig_set_in,
    input  wire logic                        sec_trig_set_in,
    input  wire logic                        link_io_valid_set_in,
    output logic                             lock_out,
    output logic                             link_io_valid_out,
    output logic                             prim_trig_out,
    output logic                             sec_trig_out,
    output logic                             chip_quiesced_out,
    output logic                             locality_grant_out,
    // Chip status, asynchronous
    input  wire logic [LLTS_CORES-1:0]       core_sleep_in,
    input  wire logic                        pmc_clk_stopped_in,
    input  wire logic [LLTS_IO_UNITS-1:0]    unit_halted_in,
    input  wire logic [LLTS_CHIPS-1:0]       peer_prim_in,
    input  wire logic [LLTS_CHIPS-1:0]       peer_sec_in,
    input  wire logic [LLTS_CHIPS-1:0]       peer_quiesced_in,
    input  wire logic                        halt_release_in,
    // Boot engine memory refresh
    output logic                             code_refresh_req_out,
    input  wire logic                        code_refresh_done_in,
    // Control towards units and core
    output logic      [LLTS_IO_UNITS-1:0]    halt_req_out,
    output logic                             checkstop_out,
    output logic      [LLTS_ADDR_W-1:0]      engine_pc_out,
    output logic                             scan_core_out,
    output logic                             verify_load_out,
    output logic      [LLTS_ADDR_W-1:0]      next_fetch_address_out,
    output logic                             core_start_out,
    output logic                             seq_busy_out
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    typedef enum logic [3:0] {
        S_IDLE, S_REFRESH, S_CORES, S_PMC, S_HALT, S_UNITS,
        S_CHECK, S_QUIESCED, S_PEERS, S_GRANT, S_SCAN, S_LOAD,
        S_START, S_STOP
    } llts_state_type;

    llts_state_type           state_r;   // Sequencer state
    logic [7:0]               wait_r;    // Scan settle counter
    logic [LLTS_CORES-1:0]    core_s;    // Synchronised core sleep
    logic                     pmc_s;     // Synchronised clock stop
    logic [LLTS_IO_UNITS-1:0] unit_s;    // Synchronised halted flags
    logic [LLTS_CHIPS-1:0]    pprim_s;   // Peer primary triggers
    logic [LLTS_CHIPS-1:0]    psec_s;    // Peer secondary triggers
    logic [LLTS_CHIPS-1:0]    pquie_s;   // Peer quiesced flags
    logic                     rel_s;     // Halt release from payload
    logic                     refr_s;    // Refresh complete
    logic                     trig_any;  // Either trigger held
    logic                     trig_d_r;  // Trigger level, last cycle
    logic                     trig_rise; // Trigger rising edge
    logic                     roles_ok;  // Exactly one primary; each chip primary xor secondary
    logic [LLTS_MBOX_W-1:0]   rdata  [LLTS_LINKS];
    logic [LLTS_LINKS-1:0]    refused;
    logic [2:0]               prim_cnt;  // Primaries across chips

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    llts_sync #(.W(LLTS_CORES + 1 + LLTS_IO_UNITS + 2)) u_sync_a (
        .core_clk_in (core_clk_in),
        .reset_n_in  (reset_n_in),
        .async_in    ({core_sleep_in, pmc_clk_stopped_in, unit_halted_in,
                       halt_release_in, code_refresh_done_in}),
        .sync_out    ({core_s, pmc_s, unit_s, rel_s, refr_s})
    );

    llts_sync #(.W(3 * LLTS_CHIPS)) u_sync_b (
        .core_clk_in (core_clk_in),
        .reset_n_in  (reset_n_in),
        .async_in    ({peer_prim_in, peer_sec_in, peer_quiesced_in}),
        .sync_out    ({pprim_s, psec_s, pquie_s})
    );

    ////////////////////////////////////////////////////////////////////////
    // Mailboxes, one instance per link
    for (genvar g = 0; g < LLTS_LINKS; g++) begin : g_link
        llts_mailbox u_mbox (
            .core_clk_in    (core_clk_in),
            .reset_n_in     (reset_n_in),
            .wr_en_in       (mbox_wr_en_in[g]),
            .rd_en_in       (mbox_rd_en_in[g]),
            .sel_in         (mbox_sel_in),
            .wdata_in       (mbox_wdata_in),
            .lock_in        (lock_out),
            .rdata_out      (rdata[g]),
            .rd_refused_out (refused[g])
        );
    end

    // Merge link read data; only one link is read at a time
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mbox_rdata_out      <= LLTS_MBOX_RST;
            mbox_rd_refused_out <= 1'b0;
        end else begin
            mbox_rdata_out      <= rdata[0] | rdata[1] | rdata[2];
            mbox_rd_refused_out <= |refused; // [R2]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel lock and link valid; neither has any clear path
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lock_out <= 1'b0;
        end else if (lock_set_in) begin
            lock_out <= 1'b1; // [R3]
        end
    end

    // Valid only accepted once the channel is locked, guarding order
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            link_io_valid_out <= 1'b0;
        end else if (link_io_valid_set_in && lock_out) begin
            link_io_valid_out <= 1'b1; // [R4]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Launch trigger bits; host sets, sequencer clears
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prim_trig_out <= 1'b0;
            sec_trig_out  <= 1'b0;
        end else if (prim_trig_set_in || sec_trig_set_in) begin
            // Host set wins over a same-cycle sequencer clear
            prim_trig_out <= prim_trig_out | prim_trig_set_in; // [R6]
            sec_trig_out  <= sec_trig_out | sec_trig_set_in;
        end else if (state_r == S_GRANT) begin
            prim_trig_out <= 1'b0; // [R18] [R19]
            sec_trig_out  <= 1'b0;
        end
    end

    assign trig_any  = prim_trig_out | sec_trig_out;
    assign trig_rise = trig_any & ~trig_d_r;

    // Edge detector on the trigger level
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            trig_d_r <= 1'b0;
        end else begin
            trig_d_r <= trig_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Role check across chips (local chip included in peer vectors)
    always_comb begin
        prim_cnt = '0;
        for (int i = 0; i < LLTS_CHIPS; i++) begin
            prim_cnt = prim_cnt + 3'(pprim_s[i]);
        end
    end

    assign roles_ok = (prim_cnt == 3'h1) && (&(pprim_s ^ psec_s)); // [R14]

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state machine; each wait state polls until satisfied
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= S_IDLE;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    if (trig_rise) begin
                        state_r <= S_REFRESH; // [R6] [R8]
                    end
                end
                S_REFRESH: begin
                    if (refr_s) begin
                        state_r <= S_CORES; // [R8]
                    end
                end
                S_CORES: begin
                    if (&core_s) begin
                        state_r <= S_PMC; // [R9] [R23]
                    end
                end
                S_PMC: begin
                    if (pmc_s) begin
                        state_r <= S_HALT; // [R10] [R23]
                    end
                end
                S_HALT:     state_r <= S_UNITS; // [R11]
                S_UNITS: begin
                    if ((&unit_s) && (&core_s)) begin
                        state_r <= S_CHECK; // [R13] [R23]
                    end
                end
                S_CHECK:    state_r <= roles_ok ? S_QUIESCED : S_STOP; // [R14]
                S_QUIESCED: state_r <= S_PEERS; // [R15]
                S_PEERS: begin
                    if (&pquie_s) begin
                        state_r <= S_GRANT; // [R16]
                    end
                end
                S_GRANT: begin
                    // Secondary chips leave here; primary goes on
                    state_r <= prim_trig_out ? S_SCAN : S_IDLE; // [R18]
                end
                S_SCAN: begin
                    if (wait_r == 8'h00) begin
                        state_r <= S_LOAD; // [R19]
                    end
                end
                S_LOAD: begin
                    if (refr_s) begin
                        state_r <= S_START; // [R19]
                    end
                end
                S_START:    state_r <= S_IDLE; // [R20]
                S_STOP:     state_r <= S_STOP; // Held until chip reset
                default:    state_r <= S_STOP;
            endcase
        end
    end

    // Scan settle counter, loaded at grant
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wait_r <= 8'h00;
        end else if (state_r == S_GRANT) begin
            wait_r <= LLTS_SCAN_CNT - 8'h01; // Zero counts as a cycle
        end else if (state_r == S_SCAN && wait_r != 8'h00) begin
            wait_r <= wait_r - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer-owned security bits; a host input reaches them only through a trigger rise, which clears both
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            chip_quiesced_out  <= 1'b0;
            locality_grant_out <= 1'b0;
        end else if (trig_rise) begin
            chip_quiesced_out  <= 1'b0; // [R7] [R22]
            locality_grant_out <= 1'b0;
        end else if (state_r == S_QUIESCED) begin
            chip_quiesced_out  <= 1'b1; // [R15]
        end else if (state_r == S_GRANT) begin
            locality_grant_out <= 1'b1; // [R17]
        end
    end

    // Halt requests; released only by the authenticated payload
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            halt_req_out <= '0;
        end else if (state_r == S_HALT) begin
            halt_req_out <= '1; // [R11] [R12]
        end else if (rel_s) begin
            halt_req_out <= '0; // [R11]
        end
    end

    // Checkstop is final until reset
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            checkstop_out <= 1'b0;
        end else if (state_r == S_STOP) begin
            checkstop_out <= 1'b1; // [R14]
        end
    end

    // Code refresh request and engine branch address
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            code_refresh_req_out <= 1'b0;
            engine_pc_out        <= LLTS_ADDR_RST;
        end else begin
            code_refresh_req_out <= (state_r == S_REFRESH) ||
                                    (state_r == S_LOAD); // [R8] [R19]
            if (state_r == S_REFRESH && refr_s) begin
                engine_pc_out <= LLTS_ENTRY_ADDR; // [R8]
            end
        end
    end

    // Core restart outputs of the initiating chip
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            scan_core_out          <= 1'b0;
            verify_load_out        <= 1'b0;
            next_fetch_address_out <= LLTS_ADDR_RST;
            core_start_out         <= 1'b0;
        end else begin
            scan_core_out   <= (state_r == S_SCAN); // [R19]
            verify_load_out <= (state_r == S_LOAD);
            core_start_out  <= (state_r == S_START); // [R20]
            if (state_r == S_LOAD) begin
                next_fetch_address_out <= LLTS_VERIFY_ADDR; // [R19]
            end
        end
    end

    // Busy flag for host visibility
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            seq_busy_out <= 1'b0;
        end else begin
            seq_busy_out <= (state_r != S_IDLE);
        end
    end

    // Private TPM I2C lies outside; no port goes to the service processor [R5]
endmodule
`default_nettype wire

// ### src/llts_pkg.sv
`default_nettype none
// Shared constants for the late-launch trust sequencer
package llts_pkg;
    // Number of inter-node links and mailbox sets per link
    localparam int          LLTS_LINKS       = 3;
    localparam int          LLTS_MBOX_SETS   = 4;
    localparam int          LLTS_SECURE_SET  = 0;
    localparam int          LLTS_MBOX_W      = 32;
    // Units and chips watched by the sequencer
    localparam int          LLTS_CORES       = 4;
    localparam int          LLTS_IO_UNITS    = 5;
    localparam int          LLTS_CHIPS       = 4;
    localparam int          LLTS_ADDR_W      = 16;
    // Reset values
    localparam logic [31:0] LLTS_MBOX_RST    = 32'h0000_0000;
    localparam logic [15:0] LLTS_ADDR_RST    = 16'h0000;
    // Fetch-address table value for late launch (arbitrary default)
    localparam logic [15:0] LLTS_ENTRY_ADDR  = 16'h0100;
    localparam logic [15:0] LLTS_VERIFY_ADDR = 16'h0200;
    // Scan settle cycles: 80 ns at 125 MHz
    localparam logic [7:0]  LLTS_SCAN_CNT    = 8'h0A;
endpackage
`default_nettype wire

// ### src/llts_sync.sv
`default_nettype none
// Two-flop synchroniser for a bus of asynchronous levels
module llts_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk_in,
    input  wire logic         reset_n_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;   // First stage, read only by the second stage

    // Both stages clear on reset
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ### src/llts_mailbox.sv
`default_nettype none
// Mailbox register sets of one inter-node link
module llts_mailbox
    import llts_pkg::*;
(
    input  wire logic                      core_clk_in,
    input  wire logic                      reset_n_in,
    input  wire logic                      wr_en_in,
    input  wire logic                      rd_en_in,
    input  wire logic [1:0]                sel_in,
    input  wire logic [LLTS_MBOX_W-1:0]    wdata_in,
    input  wire logic                      lock_in,
    output logic      [LLTS_MBOX_W-1:0]    rdata_out,
    output logic                           rd_refused_out
);
    logic [LLTS_MBOX_W-1:0] mbox_r [LLTS_MBOX_SETS];  // Four sets per link
    logic                   secure_sel;

    // Set zero carries nonces; the other three are general use
    assign secure_sel = (sel_in == 2'(LLTS_SECURE_SET)); // [R1]

    // Writes always land; only reads of the secure set are guarded
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < LLTS_MBOX_SETS; i++) begin
                mbox_r[i] <= LLTS_MBOX_RST;
            end
        end else if (wr_en_in) begin
            mbox_r[sel_in] <= wdata_in; // [R1]
        end
    end

    // Refused read returns zero so no nonce leaks after lock
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out      <= LLTS_MBOX_RST;
            rd_refused_out <= 1'b0;
        end else begin
            rd_refused_out <= rd_en_in && secure_sel && lock_in; // [R2]
            rdata_out      <= (rd_en_in && !(secure_sel && lock_in)) ?
                              mbox_r[sel_in] : LLTS_MBOX_RST; // [R2]
        end
    end
endmodule
`default_nettype wire

// ### tb/llts_props.sv
`default_nettype none
// Port-level checks on the trust sequencer top
module llts_props
    import llts_pkg::*;
(
    input wire logic                     core_clk_in,
    input wire logic                     reset_n_in,
    input wire logic [LLTS_LINKS-1:0]    mbox_rd_en_in,
    input wire logic [1:0]               mbox_sel_in,
    input wire logic                     mbox_rd_refused_out,
    input wire logic                     lock_out,
    input wire logic                     prim_trig_out,
    input wire logic                     sec_trig_out,
    input wire logic                     chip_quiesced_out,
    input wire logic                     locality_grant_out,
    input wire logic [LLTS_CORES-1:0]    core_sleep_in,
    input wire logic                     pmc_clk_stopped_in,
    input wire logic [LLTS_IO_UNITS-1:0] unit_halted_in,
    input wire logic [LLTS_CHIPS-1:0]    peer_quiesced_in,
    input wire logic                     halt_release_in,
    input wire logic [LLTS_IO_UNITS-1:0] halt_req_out,
    input wire logic                     checkstop_out,
    input wire logic [LLTS_ADDR_W-1:0]   next_fetch_address_out,
    input wire logic                     scan_core_out,
    input wire logic                     core_start_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    // Scan holds for eight cycles of its ten-cycle settle time; a short scan corrupts the core
    sequence scan_run;
        scan_core_out [*8];
    endsequence
    // Start carries the verification entry and lasts one cycle
    sequence start_pulse;
        next_fetch_address_out == LLTS_VERIFY_ADDR && !prim_trig_out
        ##1 !core_start_out;
    endsequence
    chk_lock_sticky:
        assert property (lock_out |=> lock_out) else $error("lock dropped");
    chk_secure_refused:
        assert property ((|mbox_rd_en_in) && lock_out && mbox_sel_in == 2'h0
            |-> ##[2:3] mbox_rd_refused_out) else $error("secure read open");
    chk_open_read:
        assert property ((|mbox_rd_en_in) && mbox_sel_in != 2'h0
            |-> ##2 !mbox_rd_refused_out ##1 !mbox_rd_refused_out)
            else $error("general set refused");
    chk_trig_clears:
        assert property ($rose(prim_trig_out) || $rose(sec_trig_out)
            |-> ##3 !chip_quiesced_out && !locality_grant_out)
            else $error("flags not cleared");
    chk_halt_gate:
        assert property ($rose(|halt_req_out)
            |-> pmc_clk_stopped_in && &core_sleep_in)
            else $error("halt raised early");
    chk_halt_holds:
        assert property ($fell(|halt_req_out) |-> $past(halt_release_in, 2))
            else $error("halt dropped unasked");
    chk_quiesce_gate:
        assert property ($rose(chip_quiesced_out)
            |-> &unit_halted_in && &core_sleep_in)
            else $error("quiesced too soon");
    chk_grant_gate:
        assert property ($rose(locality_grant_out)
            |-> chip_quiesced_out && &peer_quiesced_in)
            else $error("grant too soon");
    chk_scan_length:
        assert property ($rose(scan_core_out) |-> scan_run)
            else $error("scan cut short");
    chk_start_entry:
        assert property (core_start_out |-> start_pulse)
            else $error("bad core start");
    chk_stop_sticky:
        assert property (checkstop_out |=> checkstop_out && !locality_grant_out)
            else $error("checkstop lost");
endmodule
bind llts_top llts_props u_props (.*);
`default_nettype wire

// ### tb/llts_units.sv
`default_nettype none
// Far side: I/O units and boot memory answering the sequencer
module llts_units
    import llts_pkg::*;
#(
    parameter int DLY = 3  // Drain and copy time in cycles
) (
    input  wire logic                     core_clk_in,
    input  wire logic [LLTS_IO_UNITS-1:0] halt_req_in,
    input  wire logic                     refresh_req_in,
    output logic      [LLTS_IO_UNITS-1:0] halted_out,
    output logic                          refresh_done_out
);
    int hcnt = 0;  // Cycles the halt request has stood
    int rcnt = 0;  // Cycles the refresh request has stood
    // Units drain, then stay quiet while asked; done stands while asked
    always_ff @(posedge core_clk_in) begin
        hcnt             <= (|halt_req_in) ? hcnt + 1 : 0;
        halted_out       <= (hcnt >= DLY) ? halt_req_in : '0;
        rcnt             <= refresh_req_in ? rcnt + 1 : 0;
        refresh_done_out <= refresh_req_in && rcnt >= DLY;
    end
endmodule
`default_nettype wire

// ### tb/llts_test.sv
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
`define UNTIL(c) begin n = 0; while (!(c) && n < 400) begin \
    @(posedge core_clk_in); #1; n++; end end
module llts_test
    import llts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk_in = 1'h0, reset_n_in = 1'h0;
    logic [2:0] mbox_wr_en_in = 3'h0, mbox_rd_en_in = 3'h0;
    logic [1:0] mbox_sel_in = 2'h0;
    logic [31:0] mbox_wdata_in = 32'h0, mbox_rdata_out;
    logic       lock_set_in = 1'h0, prim_trig_set_in = 1'h0;
    logic       sec_trig_set_in = 1'h0, link_io_valid_set_in = 1'h0;
    logic       pmc_clk_stopped_in = 1'h0, halt_release_in = 1'h0;
    logic [3:0] core_sleep_in = 4'h7, peer_quiesced_in = 4'h0;
    logic [3:0] peer_prim_in = 4'h1, peer_sec_in = 4'hE;
    logic [4:0] unit_halted_in, halt_req_out;
    logic       code_refresh_done_in, code_refresh_req_out;
    logic       mbox_rd_refused_out, lock_out, link_io_valid_out;
    logic       prim_trig_out, sec_trig_out, chip_quiesced_out;
    logic       locality_grant_out, checkstop_out, scan_core_out;
    logic       verify_load_out, core_start_out, seq_busy_out;
    logic [15:0] engine_pc_out, next_fetch_address_out;
    int         errors = 0, checked = 0, n = 0, cyc = 0;
    llts_top DUT (.*);
    llts_units u_units (.core_clk_in, .halt_req_in(halt_req_out),
        .refresh_req_in(code_refresh_req_out), .halted_out(unit_halted_in),
        .refresh_done_out(code_refresh_done_in));
    // 125 MHz clock
    initial forever #4 core_clk_in = ~core_clk_in;
    // Hang guard, far above the longest test
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge core_clk_in);
    endtask
    // One mailbox write, strobe held for exactly one edge
    task automatic mb_wr(int l, logic [1:0] s, logic [31:0] d);
        @(posedge core_clk_in);
        mbox_wr_en_in <= 3'h1 << l;
        mbox_sel_in <= s;
        mbox_wdata_in <= d;
        @(posedge core_clk_in);
        mbox_wr_en_in <= 3'h0;
    endtask
    // Read; answer stands one cycle, two edges after the strobe
    task automatic mb_rd(int l, logic [1:0] s, logic [31:0] d, logic r);
        @(posedge core_clk_in);
        mbox_rd_en_in <= 3'h1 << l;
        mbox_sel_in <= s;
        @(posedge core_clk_in);
        mbox_rd_en_in <= 3'h0;
        tick(1);
        #1 `CHK(mbox_rdata_out, d)
        `CHK(mbox_rd_refused_out, r)
    endtask
    initial begin
        tick(5);
        reset_n_in <= 1'h1;
        // Every link and set keeps its own word while unlocked
        for (int i = 0; i < LLTS_LINKS * LLTS_MBOX_SETS; i++) begin
            mb_wr(i / 4, 2'(i), 32'hA500_0000 + 32'(i));
        end
        for (int i = 0; i < LLTS_LINKS * LLTS_MBOX_SETS; i++) begin
            mb_rd(i / 4, 2'(i), 32'hA500_0000 + 32'(i), 1'h0);
        end
        // Lock, then links valid, in firmware order
        tick(1);
        lock_set_in <= 1'h1;
        tick(1);
        lock_set_in <= 1'h0;
        link_io_valid_set_in <= 1'h1;
        tick(1);
        link_io_valid_set_in <= 1'h0;
        for (int l = 0; l < LLTS_LINKS; l++) begin
            mb_rd(l, 2'h0, 32'h0, 1'h1);
            mb_rd(l, 2'h3, 32'hA500_0003 + 32'(l * 4), 1'h0);
        end
        `CHK(lock_out, 1'h1)
        `CHK(link_io_valid_out, 1'h1)
        // Primary launch; one core awake and controller running at first
        tick(1);
        prim_trig_set_in <= 1'h1;
        tick(1);
        prim_trig_set_in <= 1'h0;
        tick(30);
        #1 `CHK(halt_req_out, 5'h00)
        tick(1);
        core_sleep_in <= 4'hF;
        tick(30);
        #1 `CHK(halt_req_out, 5'h00)
        tick(1);
        pmc_clk_stopped_in <= 1'h1;
        `UNTIL(chip_quiesced_out)
        `CHK(halt_req_out, 5'h1F)
        `CHK(chip_quiesced_out, 1'h1)
        tick(30);
        peer_quiesced_in <= 4'hF;
        #1 `CHK(locality_grant_out, 1'h0)
        `UNTIL(verify_load_out)
        `CHK(code_refresh_req_out, 1'h1)
        `UNTIL(core_start_out)
        `CHK(core_start_out, 1'h1)
        `CHK(next_fetch_address_out, LLTS_VERIFY_ADDR)
        `CHK(locality_grant_out, 1'h1)
        `CHK(prim_trig_out, 1'h0)
        `CHK(engine_pc_out, LLTS_ENTRY_ADDR)
        tick(20);
        #1 `CHK(halt_req_out, 5'h1F)
        tick(1);
        halt_release_in <= 1'h1;
        `UNTIL(halt_req_out == 5'h00)
        `CHK(halt_req_out, 5'h00)
        // Secondary launch on a chip whose flags are still set
        tick(1);
        halt_release_in <= 1'h0;
        peer_quiesced_in <= 4'h0;
        peer_prim_in <= 4'h2;
        peer_sec_in <= 4'hD;
        tick(1);
        sec_trig_set_in <= 1'h1;
        tick(1);
        sec_trig_set_in <= 1'h0;
        tick(4);
        #1 `CHK(chip_quiesced_out, 1'h0)
        `CHK(locality_grant_out, 1'h0)
        tick(1);
        peer_quiesced_in <= 4'hF;
        `UNTIL(!seq_busy_out)
        `CHK(seq_busy_out, 1'h0)
        `CHK(locality_grant_out, 1'h1)
        `CHK(sec_trig_out, 1'h0)
        `CHK(scan_core_out, 1'h0)
        `CHK(checkstop_out, 1'h0)
        // Two primaries among the chips must stop the machine
        tick(1);
        halt_release_in <= 1'h1;
        tick(6);
        halt_release_in <= 1'h0;
        peer_prim_in <= 4'h3;
        peer_sec_in <= 4'hC;
        peer_quiesced_in <= 4'h0;
        prim_trig_set_in <= 1'h1;
        tick(1);
        prim_trig_set_in <= 1'h0;
        `UNTIL(checkstop_out)
        `CHK(checkstop_out, 1'h1)
        tick(10);
        #1 `CHK(locality_grant_out, 1'h0)
        report_and_stop();
    end
endmodule
`default_nettype wire
